/* cmb_pkg.sv */
// Constants, types and shared functions of the CAN message buffer store.
package cmb_pkg;

    // Register indices inside one 16-entry message buffer window (byte address is index times four).
    localparam logic [3:0] CMB_IDX_IDENT_HIGH = 4'h0;
    localparam logic [3:0] CMB_IDX_IDENT_LOW_FLAGS = 4'h1;
    localparam logic [3:0] CMB_IDX_UNUSED_A = 4'h2;
    localparam logic [3:0] CMB_IDX_UNUSED_B = 4'h3;
    localparam logic [3:0] CMB_IDX_PAYLOAD_0 = 4'h4;
    localparam logic [3:0] CMB_IDX_PAYLOAD_7 = 4'hb;
    localparam logic [3:0] CMB_IDX_LENGTH = 4'hc;
    localparam logic [3:0] CMB_IDX_PRIORITY = 4'hd;
    localparam logic [3:0] CMB_IDX_STAMP_HIGH = 4'he;
    localparam logic [3:0] CMB_IDX_STAMP_LOW = 4'hf;

    // Address regions selected by haddr[7:6].
    localparam logic [1:0] CMB_REGION_TX = 2'h0;
    localparam logic [1:0] CMB_REGION_RX = 2'h1;
    localparam logic [1:0] CMB_REGION_CTRL = 2'h2;

    // Register indices inside the control region.
    localparam logic [3:0] CMB_IDX_CONTROL = 4'h0;
    localparam logic [3:0] CMB_IDX_TX_FLAGS = 4'h1;
    localparam logic [3:0] CMB_IDX_TX_SELECT = 4'h2;
    localparam logic [3:0] CMB_IDX_RX_FLAGS = 4'h3;
    localparam logic [3:0] CMB_IDX_TX_STATUS = 4'h4;

    // Field positions.
    localparam int CMB_CTRL_TIME_BIT = 0;
    localparam int CMB_CTRL_INIT_BIT = 1;
    localparam int CMB_RTR_BIT = 4;
    localparam int CMB_IDE_BIT = 3;
    localparam int CMB_ID_LOW_LSB = 5;

    // Sizes and values after reset.
    localparam int CMB_NUM_TX = 3;
    localparam int CMB_ID_WIDTH = 11;
    localparam logic [3:0] CMB_MAX_BYTES = 4'h8;
    localparam logic [7:0] CMB_PRIO_RESET = 8'h00;
    localparam logic [2:0] CMB_EMPTY_RESET = 3'h7;
    localparam logic [1:0] CMB_CTRL_RESET = 2'h2;
    localparam logic [15:0] CMB_STAMP_ZERO = 16'h0000;

    // Transmit engine states.
    typedef enum logic {CMB_TX_IDLE, CMB_TX_BUSY} cmb_tx_state_t;

    // Number of data bytes carried by a frame: none for remote, codes above eight give eight.
    function automatic logic [3:0] cmb_byte_count(input logic [3:0] dlc, input logic rtr);
        if (rtr) begin
            return 4'h0;
        end
        if (dlc > CMB_MAX_BYTES) begin
            return CMB_MAX_BYTES;
        end
        return dlc;
    endfunction

    // Mask that keeps the first cnt bytes of a 64-bit payload.
    function automatic logic [63:0] cmb_payload_mask(input logic [3:0] cnt);
        logic [63:0] m;
        m = 64'h0;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(cnt)) begin
                m[8*i +: 8] = 8'hff;
            end
        end
        return m;
    endfunction

endpackage

/* cmb_sel_if.sv */
// Interface between the buffer store and its local priority selector.
`timescale 1ns/10ps
interface cmb_sel_if;
    logic [2:0] cand;
    logic [7:0] prio [3];
    logic [1:0] win;
    logic any;
    modport src (output cand, output prio, input win, input any);
    modport arb (input cand, input prio, output win, output any);
endinterface

/* cmb_prio_sel.sv */
// Local priority selector over the three transmit buffers.
`timescale 1ns/10ps
module cmb_prio_sel
    import cmb_pkg::*;
(
    cmb_sel_if.arb sel
);

    // Lowest value wins; a strict compare keeps the lower index on a tie.
    always_comb begin
        logic [7:0] best;
        best = 8'hff;
        sel.win = 2'h0;
        sel.any = 1'b0;
        for (int i = 0; i < CMB_NUM_TX; i++) begin
            if (sel.cand[i] && (!sel.any || sel.prio[i] < best)) begin
                best = sel.prio[i];
                sel.win = 2'(i);
                sel.any = 1'b1;
            end
        end
    end

endmodule

/* cmb_store.sv */
// CAN message buffer store: three transmit buffers, one receive buffer, stamp timer, AHB-Lite registers.
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
// Summary of operation
// - Standard identifier is 11 bits, most significant bit goes out first.
// - Identifier 10:3 sits in first register, 2:0 in bits 7:5 of second.
// - The smallest identifier value has the highest bus priority.
// - Bit 4 of second identifier register is the remote request flag.
// - Bit 3 of second identifier register selects standard or extended identifier.
// - Eight payload bytes per buffer; only the coded count is sent or received.
// - Length code in bits 3:0; codes 0 to 8 give 0 to 8 bytes.
// - Remote frames send the programmed length code but no data bytes.
// - Just before each start of frame, all non-empty transmit buffers compete.
// - The competing buffer with the lowest local priority value is chosen.
// - On equal lowest priority the lower buffer index wins.
// - With stamping on, the timer is written into the buffer on acknowledge.
// - Stamp registers are read-only; transmit stamps are read once empty and selected.
// - Stamp timer counts bit clock ticks and wraps silently.
// - Stamp timer is held at zero during initialization mode.
// - Each buffer spans 16 registers with the stamp in the last two.
// - Buffer storage is not reset; only local priorities reset to zero.
module cmb_store
    import cmb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic bit_tick,
    input wire logic sof_req,
    input wire logic tx_ack,
    input wire logic tx_abandon,
    output logic tx_valid,
    output logic [1:0] tx_index,
    output logic [10:0] tx_ident,
    output logic tx_rtr,
    output logic tx_ide,
    output logic [3:0] tx_dlc,
    output logic [3:0] tx_byte_count,
    output logic [63:0] tx_payload,
    input wire logic rx_done,
    input wire logic [10:0] rx_ident,
    input wire logic rx_rtr,
    input wire logic rx_ide,
    input wire logic [3:0] rx_dlc,
    input wire logic [63:0] rx_payload,
    output logic rx_full
);

    ////////////////////////////////////////////////////////////////////////////////
    // Storage and state.

    logic [7:0] tx_hi [3];
    logic [7:0] tx_lo [3];
    logic [63:0] tx_pay [3];
    logic [3:0] tx_len [3];
    logic [7:0] tx_prio [3];
    logic [15:0] tx_stamp [3];
    logic [7:0] rx_hi;
    logic [7:0] rx_lo;
    logic [63:0] rx_pay;
    logic [3:0] rx_len;
    logic [15:0] rx_stamp;
    logic [2:0] empty;
    logic [2:0] sel_onehot;
    logic [1:0] sel_idx;
    logic acc_ok;
    logic [1:0] ctrl;
    logic time_en;
    logic init_mode;
    logic [15:0] timer;
    cmb_tx_state_t state;
    logic rx_take;
    logic ack_take;

    // AHB-Lite data phase state.
    logic wr_q;
    logic rd_q;
    logic [1:0] region_q;
    logic [3:0] idx_q;
    logic wr_tx;
    logic wr_ctrl;
    logic [31:0] rd_word;

    cmb_sel_if sel ();

    cmb_prio_sel u_sel (
        .sel(sel)
    );

    assign time_en = ctrl[CMB_CTRL_TIME_BIT];
    assign init_mode = ctrl[CMB_CTRL_INIT_BIT];

    // Byte of a buffer window at a given index; unused and reserved bytes read zero.
    function automatic logic [7:0] buf_byte(input logic [3:0] idx, input logic [7:0] hi, input logic [7:0] lo,
                                            input logic [63:0] pay, input logic [3:0] len,
                                            input logic [7:0] prio, input logic [15:0] stamp);
        logic [7:0] b;
        b = 8'h00;
        if (idx == CMB_IDX_IDENT_HIGH) begin
            b = hi;
        end else if (idx == CMB_IDX_IDENT_LOW_FLAGS) begin
            b = lo;
        end else if (idx >= CMB_IDX_PAYLOAD_0 && idx <= CMB_IDX_PAYLOAD_7) begin
            b = pay[8*(idx - CMB_IDX_PAYLOAD_0) +: 8];
        end else if (idx == CMB_IDX_LENGTH) begin
            b = {4'h0, len};
        end else if (idx == CMB_IDX_PRIORITY) begin
            b = prio;
        end else if (idx == CMB_IDX_STAMP_HIGH) begin
            b = stamp[15:8];
        end else if (idx == CMB_IDX_STAMP_LOW) begin
            b = stamp[7:0];
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Candidate set and window access.

    // Buffers with a cleared empty flag compete for the next frame.
    always_comb begin
        sel.cand = ~empty;
        for (int i = 0; i < CMB_NUM_TX; i++) begin
            sel.prio[i] = tx_prio[i];
        end
    end

    // The selected buffer is reachable only while it is empty.
    always_comb begin
        sel_idx = sel_onehot[0] ? 2'h0 : (sel_onehot[1] ? 2'h1 : 2'h2);
        acc_ok = (sel_onehot != 3'h0) && empty[sel_idx];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: writes take no wait state, reads take one.

    // Address phase capture and the handshake flops.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            region_q <= 2'h0;
            idx_q <= 4'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            if (rd_q) begin
                hrdata <= rd_word;
                hreadyout <= 1'b1;
            end else if (hsel && hready && htrans[1]) begin
                wr_q <= hwrite;
                rd_q <= !hwrite;
                hreadyout <= hwrite;
                region_q <= haddr[7:6];
                idx_q <= haddr[5:2];
            end
        end
    end

    // Write strobes for the data phase.
    assign wr_tx = wr_q && region_q == CMB_REGION_TX && acc_ok;
    assign wr_ctrl = wr_q && region_q == CMB_REGION_CTRL;

    // Read multiplexer; unmapped addresses read zero.
    always_comb begin
        rd_word = 32'h0000_0000;
        if (region_q == CMB_REGION_TX) begin
            if (acc_ok) begin
                rd_word[7:0] = buf_byte(idx_q, tx_hi[sel_idx], tx_lo[sel_idx], tx_pay[sel_idx], tx_len[sel_idx],
                                        tx_prio[sel_idx], tx_stamp[sel_idx]);
            end
        end else if (region_q == CMB_REGION_RX) begin
            if (idx_q != CMB_IDX_PRIORITY) begin
                rd_word[7:0] = buf_byte(idx_q, rx_hi, rx_lo, rx_pay, rx_len, 8'h00, rx_stamp);
            end
        end else if (region_q == CMB_REGION_CTRL) begin
            if (idx_q == CMB_IDX_CONTROL) begin
                rd_word[1:0] = ctrl;
            end else if (idx_q == CMB_IDX_TX_FLAGS) begin
                rd_word[2:0] = empty;
            end else if (idx_q == CMB_IDX_TX_SELECT) begin
                rd_word[2:0] = sel_onehot;
            end else if (idx_q == CMB_IDX_RX_FLAGS) begin
                rd_word[0] = rx_full;
            end else if (idx_q == CMB_IDX_TX_STATUS) begin
                rd_word[2:0] = {tx_valid, tx_index};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control, flags and selection registers.

    // Control bits: stamping enable and initialization mode.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl <= CMB_CTRL_RESET;
        end else if (wr_ctrl && idx_q == CMB_IDX_CONTROL) begin
            ctrl <= hwdata[1:0];
        end
    end

    // Empty flags: software writes one to schedule, acknowledge sets; the set wins.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            empty <= CMB_EMPTY_RESET;
        end else begin
            empty <= (empty & ~((wr_ctrl && idx_q == CMB_IDX_TX_FLAGS) ? hwdata[2:0] : 3'h0))
                     | (ack_take ? 3'(3'h1 << tx_index) : 3'h0);
        end
    end

    // Selector keeps the lowest requested buffer that is empty.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sel_onehot <= 3'h0;
        end else if (wr_ctrl && idx_q == CMB_IDX_TX_SELECT) begin
            sel_onehot <= (hwdata[2:0] & empty) & ~((hwdata[2:0] & empty) - 3'h1);
        end
    end

    // Receive full flag: a stored frame sets it, writing one clears it; the set wins.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_full <= 1'b0;
        end else if (rx_take) begin
            rx_full <= 1'b1;
        end else if (wr_ctrl && idx_q == CMB_IDX_RX_FLAGS && hwdata[0]) begin
            rx_full <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Buffer storage.

    assign rx_take = rx_done && !rx_full && !init_mode;
    assign ack_take = state == CMB_TX_BUSY && tx_ack;

    // Local priorities are the only buffer bytes with a reset value.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < CMB_NUM_TX; i++) begin
                tx_prio[i] <= CMB_PRIO_RESET;
            end
        end else if (wr_tx && idx_q == CMB_IDX_PRIORITY) begin
            tx_prio[sel_idx] <= hwdata[7:0];
        end
    end

    // Transmit buffer contents written by software; stamp bytes ignore writes.
    always_ff @(posedge clk_sys) begin
        if (wr_tx) begin
            if (idx_q == CMB_IDX_IDENT_HIGH) begin
                tx_hi[sel_idx] <= hwdata[7:0];
            end else if (idx_q == CMB_IDX_IDENT_LOW_FLAGS) begin
                tx_lo[sel_idx] <= hwdata[7:0];
            end else if (idx_q >= CMB_IDX_PAYLOAD_0 && idx_q <= CMB_IDX_PAYLOAD_7) begin
                tx_pay[sel_idx][8*(idx_q - CMB_IDX_PAYLOAD_0) +: 8] <= hwdata[7:0];
            end else if (idx_q == CMB_IDX_LENGTH) begin
                tx_len[sel_idx] <= hwdata[3:0];
            end
        end
    end

    // Receive buffer: identifier, flags and only the carried bytes are stored.
    always_ff @(posedge clk_sys) begin
        if (rx_take) begin
            rx_hi <= rx_ident[10:3];
            rx_lo <= {rx_ident[2:0], rx_rtr, rx_ide, 3'h0};
            rx_len <= rx_dlc;
            rx_pay <= (rx_pay & ~cmb_payload_mask(cmb_byte_count(rx_dlc, rx_rtr)))
                      | (rx_payload & cmb_payload_mask(cmb_byte_count(rx_dlc, rx_rtr)));
        end
    end

    // Stamps are taken from the timer when a frame is acknowledged.
    always_ff @(posedge clk_sys) begin
        if (ack_take && time_en) begin
            tx_stamp[tx_index] <= timer;
        end
        if (rx_take && time_en) begin
            rx_stamp <= timer;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stamp timer.

    // Free running on bit ticks, wraps without notice, held at zero in initialization.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            timer <= CMB_STAMP_ZERO;
        end else if (init_mode) begin
            timer <= CMB_STAMP_ZERO;
        end else if (bit_tick) begin
            timer <= timer + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit engine: selects a buffer at each start of frame.

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= CMB_TX_IDLE;
            tx_valid <= 1'b0;
            tx_index <= 2'h0;
            tx_ident <= 11'h000;
            tx_rtr <= 1'b0;
            tx_ide <= 1'b0;
            tx_dlc <= 4'h0;
            tx_byte_count <= 4'h0;
            tx_payload <= 64'h0;
        end else begin
            case (state)
                CMB_TX_IDLE: begin
                    if (sof_req && !init_mode && sel.any) begin
                        state <= CMB_TX_BUSY;
                        tx_valid <= 1'b1;
                        tx_index <= sel.win;
                        tx_ident <= {tx_hi[sel.win], tx_lo[sel.win][7:CMB_ID_LOW_LSB]};
                        tx_rtr <= tx_lo[sel.win][CMB_RTR_BIT];
                        tx_ide <= tx_lo[sel.win][CMB_IDE_BIT];
                        tx_dlc <= tx_len[sel.win];
                        tx_byte_count <= cmb_byte_count(tx_len[sel.win], tx_lo[sel.win][CMB_RTR_BIT]);
                        tx_payload <= tx_pay[sel.win]
                                      & cmb_payload_mask(cmb_byte_count(tx_len[sel.win],
                                                                        tx_lo[sel.win][CMB_RTR_BIT]));
                    end
                end
                CMB_TX_BUSY: begin
                    if (tx_ack || tx_abandon) begin
                        state <= CMB_TX_IDLE;
                        tx_valid <= 1'b0;
                    end
                end
                default: begin
                    state <= CMB_TX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_start_pick;
        sof_req && !init_mode && state == CMB_TX_IDLE && sel.any;
    endsequence

    sequence s_stamp_write;
        wr_q && region_q == CMB_REGION_TX && idx_q >= CMB_IDX_STAMP_HIGH && !ack_take;
    endsequence

    a_pick_lowest_prio: assert property (
        s_start_pick ##0 (!empty[1] && !empty[0] && tx_prio[1] < tx_prio[0]) |=> tx_index != 2'h0)
        else $error("higher local priority value was chosen");

    a_tie_lower_index: assert property (
        s_start_pick ##0 (!empty[1] && !empty[2] && tx_prio[1] == tx_prio[2] && (empty[0] || tx_prio[0] > tx_prio[1]))
        |=> tx_index == 2'h1)
        else $error("tie was not given to the lower index");

    a_sof_joins: assert property (
        s_start_pick |=> tx_valid && !empty[tx_index] ##1 tx_valid || $past(tx_ack || tx_abandon))
        else $error("start of frame did not select a scheduled buffer");

    a_remote_no_bytes: assert property (
        tx_valid && tx_rtr |-> tx_byte_count == 4'h0 && tx_payload == 64'h0)
        else $error("remote frame carries data bytes");

    a_length_clamp: assert property (
        $rose(tx_valid) && !tx_rtr |-> tx_byte_count == ((tx_dlc > 4'h8) ? 4'h8 : tx_dlc))
        else $error("data byte count does not follow length code");

    a_payload_masked: assert property (
        tx_valid |-> (tx_payload & ~cmb_payload_mask(tx_byte_count)) == 64'h0)
        else $error("bytes beyond the count are presented");

    a_init_zero: assert property (
        init_mode |=> timer == 16'h0000)
        else $error("stamp timer not held at zero in initialization");

    a_timer_step: assert property (
        !init_mode && bit_tick ##1 !init_mode |-> timer == $past(timer) + 16'h0001)
        else $error("stamp timer did not advance on a bit tick");

    a_tx_stamp: assert property (
        ack_take && time_en |=> tx_stamp[$past(tx_index)] == $past(timer) && empty[$past(tx_index)])
        else $error("acknowledge did not stamp the buffer");

    a_stamp_readonly: assert property (
        s_stamp_write |=> $stable(tx_stamp[sel_idx]))
        else $error("software write changed a stamp");

endmodule

/* cmb_can_partner.sv */
// Behavioural model of the protocol core and bus nodes beyond the buffer store.
`timescale 1ns/10ps
module cmb_can_partner (
    input wire logic clk_sys,
    output logic bit_tick,
    output logic sof_req,
    output logic tx_ack,
    output logic tx_abandon,
    output logic rx_done,
    output logic [10:0] rx_ident,
    output logic rx_rtr,
    output logic rx_ide,
    output logic [3:0] rx_dlc,
    output logic [63:0] rx_payload
);
    // All strobes start quiet.
    initial begin
        {bit_tick, sof_req, tx_ack, tx_abandon, rx_done} = 5'h00;
        {rx_ident, rx_rtr, rx_ide, rx_dlc, rx_payload} = '0;
    end
    // Bit clock ticks, one per cycle, then the tick line rests.
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys) bit_tick <= 1'b1;
        @(posedge clk_sys) bit_tick <= 1'b0;
    endtask
    // Bus turns free: one selection request just before start of frame.
    task automatic start_tx();
        @(posedge clk_sys) sof_req <= 1'b1;
        @(posedge clk_sys) sof_req <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    // After a prompt or slow frame the bus acknowledges it or the node loses it.
    task automatic end_tx(input logic lost, input int dly);
        repeat (dly) @(posedge clk_sys);
        @(posedge clk_sys) {tx_ack, tx_abandon} <= {!lost, lost};
        @(posedge clk_sys) {tx_ack, tx_abandon} <= 2'h0;
        repeat (2) @(posedge clk_sys);
    endtask
    // One acknowledged received frame; afterwards its fields show the inverse.
    task automatic rx(input logic [10:0] id, input logic rt, input logic ie, input logic [3:0] dl, input logic [63:0] p);
        @(posedge clk_sys) {rx_done, rx_ident, rx_rtr, rx_ide, rx_dlc, rx_payload} <= {1'b1, id, rt, ie, dl, p};
        @(posedge clk_sys) {rx_done, rx_ident, rx_rtr, rx_ide, rx_dlc, rx_payload} <= {1'b0, ~id, ~rt, ~ie, ~dl, ~p};
        repeat (2) @(posedge clk_sys);
    endtask
endmodule

/* testbench.sv */
// Self-checking testbench of the CAN message buffer store.
`timescale 1ns/10ps
module testbench;
    import cmb_pkg::*;
    logic clk_sys, rstn, hwrite, hreadyout, hresp, bit_tick, sof_req, tx_ack, tx_abandon, tx_valid, tx_rtr, tx_ide;
    logic rx_done, rx_rtr, rx_ide, rx_full, hsel;
    logic [1:0] htrans, tx_index;
    logic [2:0] hsize;
    logic [3:0] tx_dlc, tx_byte_count, rx_dlc;
    logic [10:0] tx_ident, rx_ident;
    logic [31:0] haddr, hwdata, hrdata;
    logic [63:0] tx_payload, rx_payload;
    int n_errors = 0;
    int tests_run = 0;
    cmb_store cmb_store_i (.clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .bit_tick, .sof_req, .tx_ack, .tx_abandon, .tx_valid,
        .tx_index, .tx_ident, .tx_rtr, .tx_ide, .tx_dlc, .tx_byte_count, .tx_payload, .rx_done, .rx_ident,
        .rx_rtr, .rx_ide, .rx_dlc, .rx_payload, .rx_full);
    cmb_can_partner cmb_can_partner_i (.clk_sys, .bit_tick, .sof_req, .tx_ack, .tx_abandon, .rx_done, .rx_ident,
        .rx_rtr, .rx_ide, .rx_dlc, .rx_payload);
    ////////////////////////////////////////////////////////////////////////////
    // Clock generation.
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Compares one value and reports a mismatch.
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One single AHB-Lite transfer; waits on hready in both phases.
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_sys);
        hsel <= 1'b1;
        hsize <= 3'h2;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic rc(input logic [31:0] a, input logic [31:0] e, input string nm);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(nm, {32'h0, e}, {32'h0, r});
    endtask
    // Payload pattern of buffer b with only the first cnt bytes kept.
    function automatic logic [63:0] pay(input int b, input int cnt);
        logic [63:0] p;
        p = '0;
        for (int k = 0; k < cnt; k++) begin
            p[8*k +: 8] = 8'(16 * b + k + 1);
        end
        return p;
    endfunction
    // Fills a transmit buffer while it is empty and selected.
    task automatic load(input int b, input logic [10:0] id, input logic rt, input logic [3:0] dl, input logic [7:0] pr);
        wr(32'h88, 32'h1 << b);
        wr(32'h00, {24'h0, id[10:3]});
        wr(32'h04, {24'h0, id[2:0], rt, rt, 3'h0});
        for (int k = 0; k < 8; k++) begin
            wr(32'h10 + 32'(4 * k), 32'(16 * b + k + 1));
        end
        wr(32'h30, {28'h0, dl});
        wr(32'h34, {24'h0, pr});
        rc(32'h34, {24'h0, pr}, "tx_local_priority");
    endtask
    // Checks the frame presented towards the bus.
    task automatic txc(input int b, input logic [10:0] id, input logic rt, input logic [3:0] dl, input int cnt);
        chk("tx_valid", 64'h1, {63'h0, tx_valid});
        chk("tx_index", 64'(b), {62'h0, tx_index});
        chk("tx_ident", {53'h0, id}, {53'h0, tx_ident});
        chk("tx_rtr_ide", {62'h0, rt, rt}, {62'h0, tx_rtr, tx_ide});
        chk("tx_dlc", {60'h0, dl}, {60'h0, tx_dlc});
        chk("tx_byte_count", 64'(cnt), {60'h0, tx_byte_count});
        chk("tx_payload", pay(b, cnt), tx_payload);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog against a hung handshake.
    initial begin
        #1600000;
        n_errors++;
        end_of_test();
    end
    // Main test sequence.
    initial begin
        {rstn, hsel, hsize, hwrite, htrans, haddr, hwdata} = '0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        rc(32'h80, 32'h2, "control");
        rc(32'h84, 32'h7, "tx_flags");
        wr(32'h88, 32'h1);
        rc(32'h34, 32'h0, "prio_reset");
        rc(32'h08, 32'h0, "std_ident_unused_a");
        wr(32'h80, 32'h1);
        load(0, 11'h123, 1'b0, 4'hb, 8'h05);
        load(1, 11'h7ff, 1'b0, 4'h3, 8'h03);
        load(2, 11'h456, 1'b1, 4'h5, 8'h03);
        wr(32'h84, 32'h7);
        rc(32'h84, 32'h0, "tx_flags_sched");
        cmb_can_partner_i.ticks(5);
        cmb_can_partner_i.start_tx();
        txc(1, 11'h7ff, 1'b0, 4'h3, 3);
        rc(32'h90, 32'h5, "tx_status");
        cmb_can_partner_i.end_tx(1'b1, 0);
        cmb_can_partner_i.start_tx();
        txc(1, 11'h7ff, 1'b0, 4'h3, 3);
        cmb_can_partner_i.end_tx(1'b0, 20);
        cmb_can_partner_i.start_tx();
        txc(2, 11'h456, 1'b1, 4'h5, 0);
        cmb_can_partner_i.end_tx(1'b0, 0);
        cmb_can_partner_i.start_tx();
        txc(0, 11'h123, 1'b0, 4'hb, 8);
        cmb_can_partner_i.end_tx(1'b0, 3);
        rc(32'h84, 32'h7, "tx_flags_done");
        wr(32'h88, 32'h2);
        rc(32'h3c, 32'h5, "stamp_low_byte");
        rc(32'h38, 32'h0, "stamp_high_byte");
        wr(32'h3c, 32'hff);
        rc(32'h3c, 32'h5, "stamp_ro");
        wr(32'h80, 32'h3);
        cmb_can_partner_i.ticks(3);
        wr(32'h80, 32'h1);
        cmb_can_partner_i.ticks(2);
        cmb_can_partner_i.rx(11'h5a3, 1'b0, 1'b0, 4'h2, 64'h0123_4567_89ab_cdef);
        chk("rx_full", 64'h1, {63'h0, rx_full});
        rc(32'h8c, 32'h1, "rx_flags");
        rc(32'h40, 32'hb4, "rx_ident_high");
        rc(32'h44, 32'h60, "rx_ident_low");
        rc(32'h50, 32'hef, "rx_payload_0");
        rc(32'h54, 32'hcd, "rx_payload_1");
        rc(32'h70, 32'h2, "rx_length");
        rc(32'h7c, 32'h2, "rx_stamp");
        wr(32'h40, 32'hff);
        rc(32'h40, 32'hb4, "rx_ro");
        wr(32'h8c, 32'h1);
        rc(32'h8c, 32'h0, "rx_flags_clr");
        cmb_can_partner_i.ticks(65541);
        cmb_can_partner_i.rx(11'h001, 1'b1, 1'b1, 4'h0, 64'h0);
        rc(32'h44, 32'h38, "rx_flags_bits");
        rc(32'h7c, 32'h7, "rx_stamp_wrap");
        rc(32'ha0, 32'h0, "unmapped");
        chk("hresp", 64'h0, {63'h0, hresp});
        end_of_test();
    end
endmodule
